// ===== hw/supply_bias_pump_config_params.svh
// Offsets, field positions, reset values of the supply and bias bank.
// Assumes an APB slave with word-aligned 16-bit registers.
`ifndef SUPPLY_BIAS_PUMP_CONFIG_PARAMS_SVH
`define SUPPLY_BIAS_PUMP_CONFIG_PARAMS_SVH

// Register indices; byte address is four times the index
`define REG_A_IDX        8'h3B
`define REG_B_IDX        8'h3C
`define BIAS_A_IDX       8'h3D
`define BIAS_B_IDX       8'h3E
`define PUMP_EN_IDX      8'h4C
`define PUMP_DIS_IDX     8'h4D
`define ENV_IDX          8'h51
`define STATUS_IDX       8'h70

// Shared field positions
`define DISCH_BIT        0
`define RATE_BIT         5
`define BYPASS_BIT       4
`define LVL_HI           3
`define LVL_LO           1

// Regulator fields
`define REGA_VSEL_HI     3
`define REGA_VSEL_LO     1
`define REGB_VSEL_HI     2
`define REGB_VSEL_LO     1
`define REGB_VSEL_BAD    2'h0

// Pump and envelope fields
`define PUMP_EN_BIT      15
`define PUMP_DIS_BIT     15
`define ENV_SRC_HI       9
`define ENV_SRC_LO       8
`define DYN_PWR_BIT      0

// Status word layout
`define ST_A_LVL_HI      2
`define ST_A_LVL_LO      0
`define ST_A_REG_BIT     3
`define ST_B_LVL_HI      6
`define ST_B_LVL_LO      4
`define ST_B_REG_BIT     7
`define ST_PDIS_BIT      8
`define ST_TRACK_BIT     9

// Reset values
`define REGA_VSEL_RST    3'h6
`define REGB_VSEL_RST    2'h1
`define DISCH_RST        1'h1
`define RATE_RST         1'h1
`define BYPASS_RST       1'h1
`define LVL_RST          3'h4
`define PUMP_EN_RST      1'h0
`define ENV_SRC_RST      2'h0
`define DYN_PWR_RST      1'h0

`endif

// ===== hw/supply_bias_pump_config_pkg.sv
// Types shared by the supply, bias and pump register bank.
// Assumes the params header is compiled alongside.
`default_nettype none
package supply_bias_pump_config_pkg;

  // Bias level code, eight output levels
  typedef logic [2:0] level_type;

  // Envelope tracking source codes
  typedef enum logic [1:0] {
    SRC_AUDIO_INTERFACE_A = 2'h0,
    SRC_AUDIO_INTERFACE_B = 2'h2
  } envelope_source_type;

endpackage : supply_bias_pump_config_pkg
`default_nettype wire

// ===== hw/bias_level_apply.sv
// Applies a bias generator's level code only in regulator mode.
// Assumes fields come straight from register flops on the same clock.
`default_nettype none
`include "supply_bias_pump_config_params.svh"
module bias_level_apply (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                bypass_sel,
  input  wire supply_bias_pump_config_pkg::level_type level,
  output var  supply_bias_pump_config_pkg::level_type level_applied,
  output var  logic                                regulating
);

  // Level follows the field only while regulating; in bypass the
  // last regulated level is kept so the return to regulation is
  // glitch free at the analogue side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_applied <= `LVL_RST;
    end else if (!bypass_sel) begin
      level_applied <= level;
    end
  end

  // Regulator mode flag, the inverse of the bypass select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulating <= ~`BYPASS_RST;
    end else begin
      regulating <= ~bypass_sel;
    end
  end

endmodule : bias_level_apply
`default_nettype wire

// ===== hw/supply_bias_pump_config_regs.sv
// Supply, bias and charge pump configuration registers on APB.
// Assumes an APB master; zero wait states, 16-bit registers in the
// low half of each 32-bit word.
//
// Local design decision: register access over APB.
`default_nettype none
`include "supply_bias_pump_config_params.svh"

module supply_bias_pump_config_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  output var  logic [2:0]  regulator_a_voltage_sel,
  output var  logic        regulator_a_discharge_sel,
  output var  logic [1:0]  regulator_b_voltage_sel,
  output var  logic        regulator_b_discharge_sel,
  output var  logic        bias_a_ramp_rate,
  output var  logic        bias_a_bypass_sel,
  output var  logic [2:0]  bias_a_level,
  output var  logic        bias_a_discharge_sel,
  output var  logic [2:0]  bias_a_level_applied,
  output var  logic        bias_a_regulating,
  output var  logic        bias_b_ramp_rate,
  output var  logic        bias_b_bypass_sel,
  output var  logic [2:0]  bias_b_level,
  output var  logic        bias_b_discharge_sel,
  output var  logic [2:0]  bias_b_level_applied,
  output var  logic        bias_b_regulating,
  output var  logic        pump_enable,
  output var  logic        pump_discharge_sel,
  output var  logic        pump_discharge_active,
  output var  logic [1:0]  envelope_source_sel,
  output var  logic        dynamic_pump_power,
  output var  logic        dynamic_tracking_active
);

  // True when the address names a register of this bank
  function automatic logic is_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_mapped = 1'h0;
    if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
      unique case (i)
        `REG_A_IDX, `REG_B_IDX, `BIAS_A_IDX, `BIAS_B_IDX,
        `PUMP_EN_IDX, `PUMP_DIS_IDX, `ENV_IDX,
        `STATUS_IDX: is_mapped = 1'h1;
        default:     is_mapped = 1'h0;
      endcase
    end
  endfunction : is_mapped

  // Access phase decode
  logic        setup;       // First cycle of a transfer
  logic        access;      // Completing cycle, pready is high
  logic        bad;         // Unmapped, misaligned or read-only write
  logic        wr_ok;       // Write that takes effect this edge
  logic        lo_lane;     // Byte lane 0 enabled
  logic        hi_lane;     // Byte lane 1 enabled
  logic [7:0]  idx;         // Word index from the address
  logic [31:0] rd_word;     // Read value for the current address

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign idx     = paddr[9:2];
  assign bad     = ~is_mapped(paddr) |
                   (pwrite & (idx == `STATUS_IDX));
  assign wr_ok   = access & pwrite & ~bad;
  assign lo_lane = pstrb[0];
  assign hi_lane = pstrb[1];

  // Never stalls; every transfer completes in its access cycle
  assign pready  = 1'h1;
  // Error only shown in the access cycle
  assign pslverr = access & bad;

  // Register storage
  logic [2:0] rega_vsel_q;   // Regulator A voltage code
  logic       rega_disch_q;  // Regulator A discharge select
  logic [1:0] regb_vsel_q;   // Regulator B voltage code
  logic       regb_disch_q;  // Regulator B discharge select
  logic       ba_rate_q;     // Bias A ramp rate
  logic       ba_byp_q;      // Bias A bypass select
  logic [2:0] ba_lvl_q;      // Bias A level code
  logic       ba_disch_q;    // Bias A discharge select
  logic       bb_rate_q;     // Bias B ramp rate
  logic       bb_byp_q;      // Bias B bypass select
  logic [2:0] bb_lvl_q;      // Bias B level code
  logic       bb_disch_q;    // Bias B discharge select
  logic       pump_en_q;     // Pump enable
  logic       pump_dis_q;    // Pump discharge select
  logic [1:0] env_src_q;     // Envelope source code
  logic       dyn_pwr_q;     // Dynamic pump power
  logic       pdis_act_q;    // Pump outputs being discharged
  logic       track_q;       // Envelope tracking in force
  logic [31:0] prdata_q;     // Captured read data

  // Regulator A register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rega_vsel_q  <= `REGA_VSEL_RST;
      rega_disch_q <= `DISCH_RST;
    end else if (wr_ok && idx == `REG_A_IDX && lo_lane) begin
      rega_vsel_q  <= pwdata[`REGA_VSEL_HI:`REGA_VSEL_LO];
      rega_disch_q <= pwdata[`DISCH_BIT];
    end
  end

  // Regulator B register; the reserved voltage code is refused so
  // the supply never sees an undefined setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regb_vsel_q  <= `REGB_VSEL_RST;
      regb_disch_q <= `DISCH_RST;
    end else if (wr_ok && idx == `REG_B_IDX && lo_lane) begin
      if (pwdata[`REGB_VSEL_HI:`REGB_VSEL_LO]
          != `REGB_VSEL_BAD) begin
        regb_vsel_q <= pwdata[`REGB_VSEL_HI:`REGB_VSEL_LO];
      end
      regb_disch_q <= pwdata[`DISCH_BIT];
    end
  end

  // Bias A register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ba_rate_q  <= `RATE_RST;
      ba_byp_q   <= `BYPASS_RST;
      ba_lvl_q   <= `LVL_RST;
      ba_disch_q <= `DISCH_RST;
    end else if (wr_ok && idx == `BIAS_A_IDX && lo_lane) begin
      ba_rate_q  <= pwdata[`RATE_BIT];
      ba_byp_q   <= pwdata[`BYPASS_BIT];
      ba_lvl_q   <= pwdata[`LVL_HI:`LVL_LO];
      ba_disch_q <= pwdata[`DISCH_BIT];
    end
  end

  // Bias B register, same layout as bias A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bb_rate_q  <= `RATE_RST;
      bb_byp_q   <= `BYPASS_RST;
      bb_lvl_q   <= `LVL_RST;
      bb_disch_q <= `DISCH_RST;
    end else if (wr_ok && idx == `BIAS_B_IDX && lo_lane) begin
      bb_rate_q  <= pwdata[`RATE_BIT];
      bb_byp_q   <= pwdata[`BYPASS_BIT];
      bb_lvl_q   <= pwdata[`LVL_HI:`LVL_LO];
      bb_disch_q <= pwdata[`DISCH_BIT];
    end
  end

  // Pump enable, in the upper byte lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_en_q <= `PUMP_EN_RST;
    end else if (wr_ok && idx == `PUMP_EN_IDX && hi_lane) begin
      pump_en_q <= pwdata[`PUMP_EN_BIT];
    end
  end

  // Pump discharge select, in the upper byte lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_dis_q <= `DISCH_RST;
    end else if (wr_ok && idx == `PUMP_DIS_IDX && hi_lane) begin
      pump_dis_q <= pwdata[`PUMP_DIS_BIT];
    end
  end

  // Envelope source; reserved codes are refused and the old
  // source is kept, so tracking never follows a dead input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      env_src_q <= `ENV_SRC_RST;
    end else if (wr_ok && idx == `ENV_IDX && hi_lane) begin
      unique case (pwdata[`ENV_SRC_HI:`ENV_SRC_LO])
        supply_bias_pump_config_pkg::SRC_AUDIO_INTERFACE_A,
        supply_bias_pump_config_pkg::SRC_AUDIO_INTERFACE_B:
          env_src_q <= pwdata[`ENV_SRC_HI:`ENV_SRC_LO];
        default:
          env_src_q <= env_src_q;
      endcase
    end
  end

  // Dynamic pump power, in the lower byte lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dyn_pwr_q <= `DYN_PWR_RST;
    end else if (wr_ok && idx == `ENV_IDX && lo_lane) begin
      dyn_pwr_q <= pwdata[`DYN_PWR_BIT];
    end
  end

  // Pump state seen by the analogue side: discharge only acts
  // while the pump is off, level tracking only while it is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdis_act_q <= `DISCH_RST & ~`PUMP_EN_RST;
      track_q    <= `PUMP_EN_RST & `DYN_PWR_RST;
    end else begin
      pdis_act_q <= pump_dis_q & ~pump_en_q;
      track_q    <= dyn_pwr_q & pump_en_q;
    end
  end

  // Level gating for each bias generator
  bias_level_apply u_bias_a (
    .pclk          (pclk),
    .presetn       (presetn),
    .bypass_sel    (ba_byp_q),
    .level         (ba_lvl_q),
    .level_applied (bias_a_level_applied),
    .regulating    (bias_a_regulating)
  );

  bias_level_apply u_bias_b (
    .pclk          (pclk),
    .presetn       (presetn),
    .bypass_sel    (bb_byp_q),
    .level         (bb_lvl_q),
    .level_applied (bias_b_level_applied),
    .regulating    (bias_b_regulating)
  );

  // Read multiplexer; unused bits read as zero
  always_comb begin
    rd_word = 32'h0;
    unique case (idx)
      `REG_A_IDX: begin
        rd_word[`REGA_VSEL_HI:`REGA_VSEL_LO] = rega_vsel_q;
        rd_word[`DISCH_BIT] = rega_disch_q;
      end
      `REG_B_IDX: begin
        rd_word[`REGB_VSEL_HI:`REGB_VSEL_LO] = regb_vsel_q;
        rd_word[`DISCH_BIT] = regb_disch_q;
      end
      `BIAS_A_IDX: begin
        rd_word[`RATE_BIT]       = ba_rate_q;
        rd_word[`BYPASS_BIT]     = ba_byp_q;
        rd_word[`LVL_HI:`LVL_LO] = ba_lvl_q;
        rd_word[`DISCH_BIT]      = ba_disch_q;
      end
      `BIAS_B_IDX: begin
        rd_word[`RATE_BIT]       = bb_rate_q;
        rd_word[`BYPASS_BIT]     = bb_byp_q;
        rd_word[`LVL_HI:`LVL_LO] = bb_lvl_q;
        rd_word[`DISCH_BIT]      = bb_disch_q;
      end
      `PUMP_EN_IDX: begin
        rd_word[`PUMP_EN_BIT] = pump_en_q;
      end
      `PUMP_DIS_IDX: begin
        rd_word[`PUMP_DIS_BIT] = pump_dis_q;
      end
      `ENV_IDX: begin
        rd_word[`ENV_SRC_HI:`ENV_SRC_LO] = env_src_q;
        rd_word[`DYN_PWR_BIT] = dyn_pwr_q;
      end
      `STATUS_IDX: begin
        rd_word[`ST_A_LVL_HI:`ST_A_LVL_LO] = bias_a_level_applied;
        rd_word[`ST_A_REG_BIT] = bias_a_regulating;
        rd_word[`ST_B_LVL_HI:`ST_B_LVL_LO] = bias_b_level_applied;
        rd_word[`ST_B_REG_BIT] = bias_b_regulating;
        rd_word[`ST_PDIS_BIT]  = pdis_act_q;
        rd_word[`ST_TRACK_BIT] = track_q;
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end

  // Read data captured in the setup cycle and held through access;
  // the status word is therefore one cycle old when taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup) begin
      prdata_q <= (!pwrite && is_mapped(paddr)) ? rd_word : 32'h0;
    end
  end

  // Output wiring from the register flops
  assign prdata                    = prdata_q;
  assign regulator_a_voltage_sel   = rega_vsel_q;
  assign regulator_a_discharge_sel = rega_disch_q;
  assign regulator_b_voltage_sel   = regb_vsel_q;
  assign regulator_b_discharge_sel = regb_disch_q;
  assign bias_a_ramp_rate          = ba_rate_q;
  assign bias_a_bypass_sel         = ba_byp_q;
  assign bias_a_level              = ba_lvl_q;
  assign bias_a_discharge_sel      = ba_disch_q;
  assign bias_b_ramp_rate          = bb_rate_q;
  assign bias_b_bypass_sel         = bb_byp_q;
  assign bias_b_level              = bb_lvl_q;
  assign bias_b_discharge_sel      = bb_disch_q;
  assign pump_enable               = pump_en_q;
  assign pump_discharge_sel        = pump_dis_q;
  assign pump_discharge_active     = pdis_act_q;
  assign envelope_source_sel       = env_src_q;
  assign dynamic_pump_power        = dyn_pwr_q;
  assign dynamic_tracking_active   = track_q;

endmodule : supply_bias_pump_config_regs
`default_nettype wire

// ===== verif/supply_bias_pump_config_chk.sv
// Checker for the supply, bias and pump configuration bank.
// Bound to the top module and sees only its ports; one clock domain.
`default_nettype none
module supply_bias_pump_config_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  input wire logic        regulator_a_discharge_sel,
  input wire logic [1:0]  regulator_b_voltage_sel,
  input wire logic        regulator_b_discharge_sel,
  input wire logic        bias_a_bypass_sel,
  input wire logic [2:0]  bias_a_level,
  input wire logic [2:0]  bias_a_level_applied,
  input wire logic        bias_b_bypass_sel,
  input wire logic [2:0]  bias_b_level_applied,
  input wire logic        pump_enable,
  input wire logic        pump_discharge_sel,
  input wire logic        pump_discharge_active,
  input wire logic [1:0]  envelope_source_sel,
  input wire logic        dynamic_pump_power,
  input wire logic        dynamic_tracking_active
);
  // Single control clock, so one default clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted write to byte address a with lane m enabled
  sequence s_wr(a, m);
    psel && penable && pwrite && !pslverr && paddr == a && pstrb[m];
  endsequence
  // Two cycles of bypass in a row
  sequence s_bypass_b;
    bias_b_bypass_sel [*2];
  endsequence
  a_rega_disch_wr:
    assert property (s_wr(12'h0EC, 0) |=>
      regulator_a_discharge_sel == $past(pwdata[0]))
    else $error("regulator a discharge select not written");
  a_regb_code_ok:
    assert property (regulator_b_voltage_sel != 2'h0)
    else $error("regulator b voltage holds reserved code");
  a_regb_fields_wr:
    assert property (s_wr(12'h0F0, 0) ##0 pwdata[2:1] != 2'h0 |=>
      {regulator_b_voltage_sel, regulator_b_discharge_sel}
        == $past(pwdata[2:0]))
    else $error("regulator b fields not written");
  a_bias_a_apply:
    assert property (!bias_a_bypass_sel |=>
      bias_a_level_applied == $past(bias_a_level))
    else $error("bias a level not applied in regulator mode");
  a_bias_b_hold:
    assert property (s_bypass_b |-> $stable(bias_b_level_applied))
    else $error("bias b level moved in bypass mode");
  a_pump_en_wr:
    assert property (s_wr(12'h130, 1) |=>
      pump_enable == $past(pwdata[15]))
    else $error("pump enable not written");
  a_pump_disch_on:
    assert property (1'h1 |=> pump_discharge_active ==
      ($past(pump_discharge_sel) && !$past(pump_enable)))
    else $error("pump discharge state wrong");
  a_env_code_ok:
    assert property (envelope_source_sel[0] == 1'h0)
    else $error("envelope source holds reserved code");
  a_track_on:
    assert property (1'h1 |=> dynamic_tracking_active ==
      ($past(dynamic_pump_power) && $past(pump_enable)))
    else $error("dynamic tracking state wrong");
endmodule : supply_bias_pump_config_chk

bind supply_bias_pump_config_regs supply_bias_pump_config_chk u_chk (.*);
`default_nettype wire

// ===== verif/supply_bias_pump_config_regs_tb.sv
// Self-checking bench for the supply, bias and pump configuration bank.
// Drives APB itself; the checker is attached by its bind.
`default_nettype none
module supply_bias_pump_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Row: address, write data, strobes, expected readback
  typedef struct packed {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] x;
  } row_type;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, pready, pslverr, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic [2:0]  regulator_a_voltage_sel, bias_a_level, bias_b_level;
  logic [2:0]  bias_a_level_applied, bias_b_level_applied;
  logic [1:0]  regulator_b_voltage_sel, envelope_source_sel;
  logic        regulator_a_discharge_sel, regulator_b_discharge_sel;
  logic        bias_a_ramp_rate, bias_a_bypass_sel, bias_a_discharge_sel;
  logic        bias_b_ramp_rate, bias_b_bypass_sel, bias_b_discharge_sel;
  logic        bias_a_regulating, bias_b_regulating, pump_enable;
  logic        pump_discharge_sel, pump_discharge_active;
  logic        dynamic_pump_power, dynamic_tracking_active;
  int          failures = 0, check_count = 0;
  // Ordinary write then readback cases
  row_type     rows [18] = '{
    '{12'h0F4, 32'h16, 4'hF, 32'h16}, '{12'h0F4, 32'h3F, 4'h2, 32'h16},
    '{12'h0F4, 32'h0E, 4'hF, 32'h0E}, '{12'h0F8, 32'h2A, 4'hF, 32'h2A},
    '{12'h0EC, 32'h0, 4'hF, 32'h0}, '{12'h0EC, 32'hFFFF0003, 4'hF, 32'h3},
    '{12'h0F0, 32'h6, 4'hF, 32'h6}, '{12'h0F0, 32'h1, 4'hF, 32'h7},
    '{12'h0F0, 32'h4, 4'hF, 32'h4}, '{12'h130, 32'h8000, 4'hF, 32'h8000},
    '{12'h130, 32'h0, 4'h1, 32'h8000}, '{12'h134, 32'h0, 4'hF, 32'h0},
    '{12'h144, 32'h201, 4'hF, 32'h201}, '{12'h144, 32'h100, 4'hF, 32'h200},
    '{12'h144, 32'h300, 4'hF, 32'h200}, '{12'h144, 32'h0, 4'hF, 32'h0},
    '{12'h144, 32'h1, 4'hF, 32'h1}, '{12'h134, 32'h8000, 4'hF, 32'h8000}};
  // Bad places: unmapped, misaligned, read-only status, high bits set
  logic [11:0] bad [4] = '{12'h100, 12'h0F5, 12'h1C0, 12'h4F4};

  // 40 MHz control clock
  always #12.5 pclk = ~pclk;

  supply_bias_pump_config_regs u_supply_bias_pump_config_regs (.*);

  // Verdict and end of run
  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; request is left up so the next may follow at once
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    er = pslverr;
    // Bounded wait: a missing answer ends the run
    if (pready !== 1'h1) begin
      failures++;
      test_done();
    end
  endtask : apb

  // Release the bus for one cycle
  task idle;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : idle

  // Read one word and compare it
  task rd_chk(input logic [11:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0, 4'h0);
    chk(rd, x);
  endtask : rd_chk

  // Reset value of every word, status included
  task check_reset;
    rd_chk(12'h0EC, 32'hD);
    rd_chk(12'h0F0, 32'h3);
    rd_chk(12'h0F4, 32'h39);
    rd_chk(12'h0F8, 32'h39);
    rd_chk(12'h130, 32'h0);
    rd_chk(12'h134, 32'h8000);
    rd_chk(12'h144, 32'h0);
    rd_chk(12'h1C0, 32'h144);
    idle();
  endtask : check_reset

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    check_reset();
    $display("reset values test done");
    // Back-to-back write and readback for each row
    for (int i = 0; i < 18; i++) begin
      apb(1'h1, rows[i].a, rows[i].d, rows[i].s);
      chk(er, 1'h0);
      apb(1'h0, rows[i].a, 32'h0, 4'h0);
      chk(rd, rows[i].x);
    end
    idle();
    $display("table test done");
    // Derived state, then switch bias a to bypass and stop the pump
    chk(bias_a_level_applied, 3'h7);
    chk(bias_b_level_applied, 3'h5);
    chk(pump_discharge_active, 1'h0);
    chk(dynamic_tracking_active, 1'h1);
    apb(1'h1, 12'h0F4, 32'h12, 4'hF);
    apb(1'h1, 12'h130, 32'h0, 4'hF);
    idle();
    idle();
    chk(bias_a_level, 3'h1);
    chk(bias_a_level_applied, 3'h7);
    chk(pump_discharge_active, 1'h1);
    chk(dynamic_tracking_active, 1'h0);
    // Every field output against the values last written
    chk({regulator_a_voltage_sel, regulator_a_discharge_sel,
         regulator_b_voltage_sel, regulator_b_discharge_sel},
        32'h1C);
    chk({bias_a_ramp_rate, bias_a_bypass_sel, bias_a_level,
         bias_a_discharge_sel}, 32'h12);
    chk({bias_b_ramp_rate, bias_b_bypass_sel, bias_b_level,
         bias_b_discharge_sel}, 32'h2A);
    chk({pump_enable, pump_discharge_sel, envelope_source_sel,
         dynamic_pump_power, bias_a_regulating, bias_b_regulating},
        32'h25);
    rd_chk(12'h1C0, 32'h1D7);
    idle();
    $display("derived state test done");
    // Refused writes leave bias a untouched
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, bad[i], 32'h0, 4'hF);
      chk(er, 1'h1);
    end
    apb(1'h0, 12'h100, 32'h0, 4'h0);
    chk(rd, 32'h0);
    rd_chk(12'h0F4, 32'h12);
    idle();
    $display("refusal test done");
    // Second reset in mid-run
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(regulator_b_voltage_sel, 2'h1);
    chk(bias_a_level_applied, 3'h4);
    presetn <= 1'h1;
    @(posedge pclk);
    check_reset();
    $display("second reset test done");
    test_done();
  end
endmodule : supply_bias_pump_config_regs_tb
`default_nettype wire
